// ### hdl/pabr_pkg.sv
package pabr_pkg;

  localparam int NSLOT = 4;
  localparam int SLOT_STRIDE = 16;
  // host cycles in the strobe phase before ready is trusted
  localparam logic [1:0] RDY_SETTLE = 2'h3;

  // register offsets on the configuration port
  localparam logic [7:0] OFF_BASE = 8'h00;
  localparam logic [7:0] OFF_HIGH = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_GCTRL = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;

  // mode register field positions
  localparam int MODE_SYNC = 0;
  localparam int MODE_WM = 1;
  localparam int MODE_MUX = 2;
  localparam int MODE_WID = 3;
  localparam int MODE_SET = 8;
  localparam int MODE_ACC = 12;
  localparam int MODE_REC = 16;

  // width codes
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;

  // values after reset
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_HIGH = 32'h0000_0000;
  localparam logic [31:0] RST_MODE = 32'h0000_0010;
  localparam logic [31:0] RST_GCTRL = 32'h0000_0000;

  // host response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PABR_IDLE = 3'b000,
    PABR_ADDR = 3'b001,
    PABR_SETUP = 3'b010,
    PABR_ACC = 3'b011,
    PABR_RECOV = 3'b100,
    PABR_RESP = 3'b101
  } pabr_state_t;

  typedef struct packed {
    logic [3:0] cs_n;
    logic [31:0] addr;
    logic [31:0] data;
    logic data_oe;
    logic [3:0] be;
    logic rd_n;
    logic wr_n;
    logic rnw;
    logic ads;
  } pabr_pin_t;

endpackage

// ### hdl/pabr_bridge.sv
// Function
// - host AXI4-Lite 32-bit slave, becomes peripheral cycle
// - four slots, each with base/high window
// - sync or async chosen per slot
// - setup, access, recovery counts per slot
// - write data latched whole, strobes drive byte enables except under width matching
// - sync engine on host or peripheral clock
// - peripheral clock crossing synchronised toward the host only: clock, ready and data
// - host clock choice: no synchronisation; ready and data still pass the two-stage synchronisers
// - async cycles run on host clock only
// - sync and async paths coexist
// - slot width 8, 16 or 32 bits
// - width matching splits into several cycles
// - low address bits generated and advanced
// - byte writes lowest lane first, after acceptance
// - write acknowledged after final byte accepted
// - read bytes fill lanes from lowest
// - 8-bit read acknowledged after four bytes
// - mux mode: address phase then data
// - no mux: separate address and data
// - no mux: address strobe held low
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pabr_bridge
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // host read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration port
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  // peripheral pins
  input wire logic per_clk,
  input wire logic per_rdy,
  input wire logic [31:0] per_din,
  output var pabr_pkg::pabr_pin_t per_pins
);

  logic [31:0] base_q [pabr_pkg::NSLOT];
  logic [31:0] high_q [pabr_pkg::NSLOT];
  logic [31:0] mode_q [pabr_pkg::NSLOT];
  logic [31:0] gctrl_q;
  pabr_pkg::pabr_state_t state_q, state_d;
  logic [31:0] addr_q, wdat_q, rdat_q, cfg_rdata_q;
  logic [3:0] be_q, cnt_q;
  logic [1:0] slot_q, beat_q, resp_q, acc_age_q;
  logic rnw_q, bvalid_q, rvalid_q;
  logic clk_s1_q, clk_s2_q, clk_s3_q, rdy_s1_q, rdy_s2_q;
  logic [31:0] din_s1_q, din_s2_q;
  pabr_pkg::pabr_pin_t per_d, per_q;

  // configuration registers, one set per slot
  genvar gi;
  generate
    for (gi = 0; gi < pabr_pkg::NSLOT; gi++)
    begin : g_slot
      wire [7:0] sb = 8'(gi * pabr_pkg::SLOT_STRIDE);
      wire wr_base = cfg_wr && cfg_addr == sb + pabr_pkg::OFF_BASE;
      wire wr_high = cfg_wr && cfg_addr == sb + pabr_pkg::OFF_HIGH;
      wire wr_mode = cfg_wr && cfg_addr == sb + pabr_pkg::OFF_MODE;
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          base_q[gi] <= pabr_pkg::RST_BASE;
          high_q[gi] <= pabr_pkg::RST_HIGH;
          mode_q[gi] <= pabr_pkg::RST_MODE;
        end
        else
        begin
          if (wr_base) base_q[gi] <= cfg_wdata;
          if (wr_high) high_q[gi] <= cfg_wdata;
          if (wr_mode) mode_q[gi] <= cfg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b) gctrl_q <= pabr_pkg::RST_GCTRL;
    else if (cfg_wr && cfg_addr == pabr_pkg::OFF_GCTRL) gctrl_q <= cfg_wdata;
  end

  // configuration read, data in the following cycle
  wire [1:0] cfg_slot = cfg_addr[5:4];
  wire cfg_in_slot = cfg_addr[7:6] == 2'h0;
  wire [7:0] cfg_off = cfg_addr & 8'h0f;
  wire [31:0] status_w = {26'h0, state_q != pabr_pkg::PABR_IDLE, state_q, slot_q};
  wire [31:0] cfg_word =
    cfg_in_slot && cfg_off == pabr_pkg::OFF_BASE ? base_q[cfg_slot] :
    cfg_in_slot && cfg_off == pabr_pkg::OFF_HIGH ? high_q[cfg_slot] :
    cfg_in_slot && cfg_off == pabr_pkg::OFF_MODE ? mode_q[cfg_slot] :
    cfg_addr == pabr_pkg::OFF_GCTRL ? gctrl_q :
    cfg_addr == pabr_pkg::OFF_STATUS ? status_w : 32'h0000_0000;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b) cfg_rdata_q <= 32'h0000_0000;
    else if (cfg_rd) cfg_rdata_q <= cfg_word;
  end
  assign cfg_rdata = cfg_rdata_q;

  // pin synchronisers: first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'h0;
      {rdy_s1_q, rdy_s2_q} <= 2'h0;
      din_s1_q <= 32'h0000_0000;
      din_s2_q <= 32'h0000_0000;
    end
    else
    begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= {per_clk, clk_s1_q, clk_s2_q};
      {rdy_s1_q, rdy_s2_q} <= {per_rdy, rdy_s1_q};
      din_s1_q <= per_din;
      din_s2_q <= din_s1_q;
    end
  end

  // host request and window decode
  wire wr_req = s_axi_awvalid && s_axi_wvalid;
  wire idle = state_q == pabr_pkg::PABR_IDLE;
  wire take_wr = idle && wr_req;
  wire take_rd = idle && !wr_req && s_axi_arvalid;
  wire [31:0] req_addr = wr_req ? s_axi_awaddr : s_axi_araddr;
  logic [3:0] hit;
  logic [1:0] hit_slot;
  generate
    for (gi = 0; gi < pabr_pkg::NSLOT; gi++)
    begin : g_hit
      assign hit[gi] = req_addr >= base_q[gi] && req_addr <= high_q[gi];
    end
  endgenerate
  always_comb
  begin
    hit_slot = 2'h0;
    for (int i = pabr_pkg::NSLOT - 1; i >= 0; i--)
      if (hit[i]) hit_slot = 2'(i);
  end
  assign s_axi_awready = take_wr;
  assign s_axi_wready = take_wr;
  assign s_axi_arready = take_rd;

  // current slot attributes
  wire [31:0] mode = mode_q[slot_q];
  wire m_sync = mode[pabr_pkg::MODE_SYNC];
  wire m_wm = mode[pabr_pkg::MODE_WM];
  wire m_mux = mode[pabr_pkg::MODE_MUX];
  wire [1:0] m_wid = mode[pabr_pkg::MODE_WID +: 2];
  wire [3:0] t_set = mode[pabr_pkg::MODE_SET +: 4];
  wire [3:0] t_acc = mode[pabr_pkg::MODE_ACC +: 4];
  wire [3:0] t_rec = mode[pabr_pkg::MODE_REC +: 4];
  wire w8 = m_wm && m_wid == pabr_pkg::WID_8;
  wire w16 = m_wm && m_wid == pabr_pkg::WID_16;

  // peripheral clock edge found in the host domain (slower clock assumed)
  wire pclk_rise = clk_s2_q && !clk_s3_q;
  // sync slots step on the chosen clock, async slots on every host edge
  wire use_pclk = m_sync && gctrl_q[0];
  wire tick = use_pclk ? pclk_rise : 1'b1;
  wire last = (!w8 && !w16) || (w8 && beat_q == 2'h3) || (w16 && beat_q == 2'h1);
  wire rdy_ok = rdy_s2_q && acc_age_q == pabr_pkg::RDY_SETTLE;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      pabr_pkg::PABR_IDLE:
        if (take_wr || take_rd)
          state_d = !(|hit) ? pabr_pkg::PABR_RESP
                  : mode_q[hit_slot][pabr_pkg::MODE_MUX] ? pabr_pkg::PABR_ADDR
                  : pabr_pkg::PABR_SETUP;
      pabr_pkg::PABR_ADDR:
        if (tick) state_d = pabr_pkg::PABR_SETUP;
      pabr_pkg::PABR_SETUP:
        if (tick && cnt_q >= t_set) state_d = pabr_pkg::PABR_ACC;
      pabr_pkg::PABR_ACC:
        if (tick && cnt_q >= t_acc && rdy_ok) state_d = pabr_pkg::PABR_RECOV;
      pabr_pkg::PABR_RECOV:
        if (tick && cnt_q >= t_rec)
          state_d = last ? pabr_pkg::PABR_RESP
                  : m_mux ? pabr_pkg::PABR_ADDR : pabr_pkg::PABR_SETUP;
      pabr_pkg::PABR_RESP:
        if ((bvalid_q && s_axi_bready) || (rvalid_q && s_axi_rready))
          state_d = pabr_pkg::PABR_IDLE;
      default:
        state_d = pabr_pkg::PABR_IDLE;
    endcase
  end

  wire phase_end = state_d != state_q;
  wire byte_in = state_q == pabr_pkg::PABR_ACC && state_d == pabr_pkg::PABR_RECOV;
  wire beat_next = state_q == pabr_pkg::PABR_RECOV && phase_end && !last;
  wire [4:0] wshift = w8 ? {beat_q, 3'h0} : w16 ? {beat_q[0], 4'h0} : 5'h00;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= pabr_pkg::PABR_IDLE;
      {addr_q, wdat_q} <= 64'h0;
      {be_q, cnt_q, slot_q, beat_q, rnw_q, acc_age_q} <= 15'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= phase_end ? 4'h0 : tick ? cnt_q + 4'h1 : cnt_q;
      acc_age_q <= phase_end ? 2'h0 : acc_age_q + {1'b0, acc_age_q != pabr_pkg::RDY_SETTLE};
      if (take_wr || take_rd)
      begin
        addr_q <= req_addr;
        wdat_q <= s_axi_wdata;
        be_q <= take_wr ? s_axi_wstrb : 4'hf;
        rnw_q <= take_rd;
        slot_q <= hit_slot;
        beat_q <= 2'h0;
      end
      else if (beat_next) beat_q <= beat_q + 2'h1;
    end
  end

  // response and read data assembly
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {bvalid_q, rvalid_q} <= 2'h0;
      resp_q <= pabr_pkg::RESP_OKAY;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      if (take_wr || take_rd)
        resp_q <= |hit ? pabr_pkg::RESP_OKAY : pabr_pkg::RESP_SLVERR;
      if (state_d == pabr_pkg::PABR_RESP && state_q != pabr_pkg::PABR_RESP)
      begin
        bvalid_q <= !rnw_q && state_q != pabr_pkg::PABR_IDLE || take_wr;
        rvalid_q <= rnw_q && state_q != pabr_pkg::PABR_IDLE || take_rd;
      end
      else if (state_d == pabr_pkg::PABR_IDLE) {bvalid_q, rvalid_q} <= 2'h0;
      if (byte_in && rnw_q)
      begin
        if (w8) rdat_q[{beat_q, 3'h0} +: 8] <= din_s2_q[7:0];
        else if (w16) rdat_q[{beat_q[0], 4'h0} +: 16] <= din_s2_q[15:0];
        else rdat_q <= din_s2_q;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_bresp = resp_q;
  assign s_axi_rresp = resp_q;
  assign s_axi_rdata = rdat_q;

  // pin driving, registered toward the pads
  wire active = !idle && state_q != pabr_pkg::PABR_RESP;
  wire in_addr = state_q == pabr_pkg::PABR_ADDR;
  wire [1:0] lo = w8 ? beat_q : w16 ? {beat_q[0], 1'b0} : addr_q[1:0];
  wire [31:0] pa = {addr_q[31:2], lo};
  always_comb
  begin
    per_d.cs_n = 4'hf;
    if (active && state_q != pabr_pkg::PABR_RECOV) per_d.cs_n[slot_q] = 1'b0;
    per_d.addr = m_mux ? 32'h0000_0000 : pa;
    per_d.data = in_addr ? pa : wdat_q >> wshift;
    per_d.data_oe = active && (in_addr || !rnw_q);
    per_d.be = m_wm ? 4'hf : be_q;
    per_d.rd_n = !(state_q == pabr_pkg::PABR_ACC && rnw_q);
    per_d.wr_n = !(state_q == pabr_pkg::PABR_ACC && !rnw_q);
    per_d.rnw = rnw_q;
    per_d.ads = in_addr && m_mux;
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b) per_q <= {4'hf, 65'h0, 4'h0, 4'he};
    else per_q <= per_d;
  end
  assign per_pins = per_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_ONE_TXN: assert property (s_axi_awready || s_axi_arready
    |=> !s_axi_awready && !s_axi_arready)
    else $error("new host request taken while busy");
  AST_WDATA_FULL: assert property (take_wr |=> wdat_q == $past(s_axi_wdata))
    else $error("write data not latched whole");
  AST_OKAY: assert property ($rose(bvalid_q || rvalid_q) && $past(state_q) == pabr_pkg::PABR_RECOV
    |-> resp_q == pabr_pkg::RESP_OKAY)
    else $error("peripheral access not answered OKAY");
  AST_ADS_LOW: assert property (!m_mux |=> !per_pins.ads)
    else $error("address strobe raised without multiplexing");
  AST_HOLD_NO_TICK: assert property (!tick && active |=> $stable(state_q))
    else $error("cycle advanced without a peripheral clock edge");
  AST_ASYNC_STEP: assert property (!m_sync |-> tick)
    else $error("async slot not stepped on host clock");
  AST_LOW_ADDR: assert property (state_q == pabr_pkg::PABR_SETUP && w8
    |-> per_d.addr[1:0] == beat_q || m_mux)
    else $error("generated low address bits wrong");
  AST_LAST_BYTE: assert property (state_q == pabr_pkg::PABR_RECOV ##1
    state_q == pabr_pkg::PABR_RESP && w8 |-> $past(beat_q) == 2'h3)
    else $error("8-bit access acknowledged before four bytes");
  AST_IN_WINDOW: assert property (state_q == pabr_pkg::PABR_SETUP
    |-> addr_q >= base_q[slot_q] && addr_q <= high_q[slot_q])
    else $error("access outside the slot window");
  COV_WM_WRITE: cover property (take_wr ##[1:200] state_q == pabr_pkg::PABR_RESP && w8);
  COV_MUX_READ: cover property (state_q == pabr_pkg::PABR_ADDR && rnw_q);
  COV_SYNC_PCLK: cover property (use_pclk && state_q == pabr_pkg::PABR_ACC);

endmodule

`default_nettype wire

// ### test/pabr_per_model.sv
`timescale 1ns/1ps
`default_nettype none
module pabr_per_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // ready delay knob
  input wire logic [1:0] slow,
  // bridge pins
  input wire pabr_pkg::pabr_pin_t pins,
  output logic rdy,
  output logic [31:0] din,
  // activity counts
  output logic [7:0] beats,
  output logic [7:0] adsn
);
  logic [31:0] mem [256];
  logic [7:0] lat;
  logic lv, wp, ap, sp;
  logic [2:0] wt;
  wire logic sel = pins.cs_n != 4'hf;
  wire logic stx = !(pins.rd_n && pins.wr_n);
  wire logic [7:0] ea = lv ? lat : pins.addr[7:0];
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {rdy, lv, ap, sp, wt, lat, beats, adsn, din} <= '0;
      wp <= 1'b1;
    end
    else
    begin
      wt <= (sel && stx) ? wt + {2'h0, wt != 3'h7} : 3'h0;
      rdy <= sel && stx && wt >= {1'b0, slow};
      // released bus toggles instead of holding
      din <= (sel && !pins.rd_n) ? mem[ea] : ~din;
      if (sel && !pins.wr_n)
        mem[ea] <= pins.data;
      // address phase latched until the data strobe ends
      if (pins.ads)
        lat <= pins.data[7:0];
      lv <= pins.ads || (lv && !(sp && !stx));
      if (!pins.wr_n && wp)
        beats <= beats + 8'h01;
      if (pins.ads && !ap)
        adsn <= adsn + 8'h01;
      wp <= pins.wr_n;
      ap <= pins.ads;
      sp <= stx;
    end
  end
endmodule
`default_nettype wire

// ### test/pabr_bridge_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pabr_bridge_tb;
  logic mclk = 0;
  logic per_clk = 0;
  logic rst_b = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, cwd = 0;
  logic [3:0] wstrb = 0;
  logic awv = 0, wv = 0, arv = 0, cwr = 0, crd = 0;
  logic [7:0] caddr = 0;
  logic [1:0] slow = 0;
  logic awr, wrd, bv, arr, rv, rdy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, crdata, din;
  logic [7:0] beats, adsn;
  pabr_pkg::pabr_pin_t pins;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed;
  logic [31:0] mode [4];
  localparam logic [7:0] NB [4] = '{8'h01, 8'h04, 8'h02, 8'h01};
  localparam logic [7:0] NA [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  localparam logic [31:0] MD [4] = '{32'h0000_0010, 32'h0000_0002, 32'h0000_000b, 32'h0000_0014};

  pabr_bridge dut (.mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .cfg_addr(caddr), .cfg_wdata(cwd), .cfg_wr(cwr), .cfg_rd(crd), .cfg_rdata(crdata),
    .per_clk(per_clk), .per_rdy(rdy), .per_din(din), .per_pins(pins));
  pabr_per_model peer (.mclk(mclk), .rst_b(rst_b), .slow(slow), .pins(pins),
    .rdy(rdy), .din(din), .beats(beats), .adsn(adsn));

  always #2 mclk = ~mclk;
  // slower than mclk
  always #62.5 per_clk = ~per_clk;

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      $display("BAD %0t run hung", $time);
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic cfw(input logic [7:0] a, input logic [31:0] d);
    caddr <= a;
    cwd <= d;
    cwr <= 1'b1;
    @(posedge mclk);
    cwr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic cfr(input logic [7:0] a, input logic [31:0] e);
    caddr <= a;
    crd <= 1'b1;
    @(posedge mclk);
    crd <= 1'b0;
    @(posedge mclk);
    chk(crdata, e);
  endtask

  // address and data valid raised together
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'($urandom);
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge mclk); while (awr !== 1'b1);
    chk({31'h0, wrd}, 32'h0000_0001);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge mclk); while (bv !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, d, input logic [1:0] er, input bit cd);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rv !== 1'b1);
    chk({30'h0, rresp}, {30'h0, er});
    if (cd)
      chk(rdata, d);
  endtask

  function automatic logic [31:0] base(input int n);
    return 32'((n + 1) << 12);
  endfunction

  initial
  begin
    logic [31:0] a, d;
    logic [7:0] b0, s0;
    int n;
    seed = $urandom(20132);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    cfr(pabr_pkg::OFF_MODE, pabr_pkg::RST_MODE);
    cfr(pabr_pkg::OFF_HIGH, pabr_pkg::RST_HIGH);
    cfr(pabr_pkg::OFF_GCTRL, pabr_pkg::RST_GCTRL);
    cfr(8'h3c, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      mode[i] = MD[i] | (32'($urandom % 64) << 8) | (32'($urandom % 4) << 16);
      cfw(8'(16 * i) + pabr_pkg::OFF_BASE, base(i));
      cfw(8'(16 * i) + pabr_pkg::OFF_HIGH, base(i) + 32'h0000_0fff);
      cfw(8'(16 * i) + pabr_pkg::OFF_MODE, mode[i]);
      cfr(8'(16 * i) + pabr_pkg::OFF_MODE, mode[i]);
    end
    // unmapped host access: error, no peripheral cycle
    b0 = beats;
    wr(32'h0000_0100, 32'h1234_5678, pabr_pkg::RESP_SLVERR);
    chk({24'h0, beats - b0}, 32'h0000_0000);
    rd(32'h0000_0100, 32'h0, pabr_pkg::RESP_SLVERR, 0);
    for (int i = 0; i < 32; i++)
    begin
      if (i == 16)
        cfw(pabr_pkg::OFF_GCTRL, 32'h0000_0001);
      n = (i < 4) ? i : int'($urandom % 4);
      // word aligned
      a = base(n) + 32'(($urandom % 16) * 4);
      d = $urandom;
      slow <= 2'($urandom);
      b0 = beats;
      s0 = adsn;
      wr(a, d, pabr_pkg::RESP_OKAY);
      chk({24'h0, beats - b0}, {24'h0, NB[n]});
      chk({24'h0, adsn - s0}, {24'h0, NA[n]});
      rd(a, d, pabr_pkg::RESP_OKAY, 1);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
